// ### shared/flash_spi_consts.vh
// Purpose: Shared constants for the serial user flash command slave
// Assumes: Included by bare name from design files
// Notes:   Opcodes, status layout, command encodings and buffer sizes
`ifndef FLASH_SPI_CONSTS_VH
`define FLASH_SPI_CONSTS_VH

// Opcodes
`define OPC_LATCH_SET   8'h06
`define OPC_LATCH_CLR   8'h04
`define OPC_STAT_RD     8'h05
`define OPC_STAT_WR     8'h01
`define OPC_READ        8'h03
`define OPC_WRITE       8'h02
`define OPC_PART_WIPE   8'h20
`define OPC_WHOLE_WIPE  8'h60

// Status byte bit positions
`define ST_BUSY_BIT     0
`define ST_LATCH_BIT    1
`define ST_PROT_LO_BIT  2
`define ST_PROT_HI_BIT  3

// Reset values and the full-protection level
`define PROT_RESET      2'h0
`define LATCH_RESET     1'b0
`define PROT_FULL       2'h3

// Field lengths in bits
`define OPC_BITS        5'h08
`define EXT_FIELD_BITS  5'h10
`define BASE_FIELD_BITS 5'h08
`define STAT_BITS       4'h8

// Commands to the flash engine
`define CMD_NONE        2'h0
`define CMD_PROG        2'h1
`define CMD_SECTOR      2'h2
`define CMD_ALL         2'h3

// Command buffer
`define CMD_WIDTH       27
`define CMD_DEPTH       32
`define CMD_AW          5

`endif

// ### verilog/flash_spi_slave.v
// Purpose: Serial command slave giving a master access to user flash
// Assumes: clk 100 MHz; sck, ncs, si are asynchronous pins
// Notes:   Flash cells sit outside; reads via a port, changes via a buffer
`timescale 1ns/100ps
`include "flash_spi_consts.vh"

module cmd_fifo #(
  parameter WIDTH = `CMD_WIDTH,
  parameter DEPTH = `CMD_DEPTH,
  parameter AW    = `CMD_AW
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_reg;
  reg  [AW-1:0]    rd_ptr_reg;
  reg  [AW:0]      count_reg;
  wire             push;
  wire             pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      localparam [AW-1:0] IDX = i;
      always @(posedge clk)
      begin
        if (push && (wr_ptr_reg == IDX))
          mem[i] <= in_data;
      end
    end
  endgenerate

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

module flash_spi_slave (
  input  wire        clk,
  input  wire        reset,
  input  wire        sck,
  input  wire        ncs,
  input  wire        si,
  output wire        so,
  output wire        so_oe,
  input  wire        extended_mode,
  input  wire        read_only,
  output wire [8:0]  flash_rd_addr,
  input  wire [15:0] flash_rd_data,
  input  wire        engine_busy,
  output wire        cmd_valid,
  input  wire        cmd_ready,
  output wire [1:0]  cmd_op,
  output wire [8:0]  cmd_addr,
  output wire [15:0] cmd_data,
  output wire        busy_flag,
  output wire [7:0]  status_byte
);
  localparam [6:0] ST_OPC   = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_RDATA = 7'h04;
  localparam [6:0] ST_WDATA = 7'h08;
  localparam [6:0] ST_STAT  = 7'h10;
  localparam [6:0] ST_SWR   = 7'h20;
  localparam [6:0] ST_WAIT  = 7'h40;

  reg  [2:0]  sck_sync_reg;
  reg  [2:0]  ncs_sync_reg;
  reg  [1:0]  si_sync_reg;
  reg  [6:0]  state_reg;
  reg  [4:0]  cnt_reg;
  reg  [15:0] sr_reg;
  reg  [1:0]  cur_op_reg;
  reg  [15:0] osr_reg;
  reg  [3:0]  ocnt_reg;
  reg         so_reg;
  reg         so_oe_reg;
  reg  [8:0]  rd_addr_reg;
  reg         rd_end_reg;
  reg         latch_reg;
  reg  [1:0]  protect_reg;
  reg  [1:0]  arm_op_reg;
  reg  [8:0]  arm_addr_reg;
  reg  [15:0] arm_data_reg;
  reg         arm_swr_reg;
  reg  [1:0]  swr_val_reg;
  reg         pend_valid_reg;
  reg  [26:0] pend_word_reg;
  wire        fifo_in_ready;
  wire [26:0] fifo_out;
  wire        sck_rise;
  wire        sck_fall;
  wire        selected;
  wire        ncs_rise;
  wire        si_bit;
  wire [7:0]  opcode;
  wire [4:0]  field_len;
  wire [8:0]  addr_in;
  wire [15:0] load_word;
  wire [3:0]  load_len;
  wire        busy;

  // Whole-array protection is the only defined level besides none
  function prot_hit;
    input [1:0] bp;
    input [8:0] addr;
    begin
      prot_hit = (bp == `PROT_FULL) && (addr <= 9'h1ff);
    end
  endfunction

  assign sck_rise  = sck_sync_reg[1] && !sck_sync_reg[2];
  assign sck_fall  = !sck_sync_reg[1] && sck_sync_reg[2];
  assign selected  = !ncs_sync_reg[1];
  assign ncs_rise  = ncs_sync_reg[1] && !ncs_sync_reg[2];
  assign si_bit    = si_sync_reg[1];
  assign opcode    = {sr_reg[6:0], si_bit};
  assign field_len = extended_mode ? `EXT_FIELD_BITS : `BASE_FIELD_BITS;
  // Top seven of sixteen bits fall away; Base keeps sector 0 only
  assign addr_in   = extended_mode ? {sr_reg[7:0], si_bit} :
                     {1'b0, sr_reg[6:0], si_bit};
  assign busy      = pend_valid_reg || cmd_valid || engine_busy;
  assign status_byte = {4'h0, protect_reg, latch_reg, busy};
  assign load_word = (state_reg == ST_STAT) ? {status_byte, 8'h00} :
                     extended_mode ? flash_rd_data :
                     {flash_rd_data[7:0], 8'h00};
  assign load_len  = ((state_reg == ST_STAT) || !extended_mode) ?
                     (`STAT_BITS - 4'h1) : 4'hf;
  assign so        = so_reg;
  assign so_oe     = so_oe_reg;
  assign flash_rd_addr = rd_addr_reg;
  assign busy_flag = busy;
  assign cmd_op    = fifo_out[26:25];
  assign cmd_addr  = fifo_out[24:16];
  assign cmd_data  = fifo_out[15:0];

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sck_sync_reg <= 3'h0;
      ncs_sync_reg <= 3'h7;
      si_sync_reg  <= 2'h0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck};
      ncs_sync_reg <= {ncs_sync_reg[1:0], ncs};
      si_sync_reg  <= {si_sync_reg[0], si};
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg      <= ST_OPC;
      cnt_reg        <= 5'h00;
      sr_reg         <= 16'h0000;
      cur_op_reg     <= `CMD_NONE;
      osr_reg        <= 16'h0000;
      ocnt_reg       <= 4'h0;
      so_reg         <= 1'b0;
      so_oe_reg      <= 1'b0;
      rd_addr_reg    <= 9'h000;
      rd_end_reg     <= 1'b0;
      latch_reg      <= `LATCH_RESET;
      protect_reg    <= `PROT_RESET;
      arm_op_reg     <= `CMD_NONE;
      arm_addr_reg   <= 9'h000;
      arm_data_reg   <= 16'h0000;
      arm_swr_reg    <= 1'b0;
      swr_val_reg    <= 2'h0;
      pend_valid_reg <= 1'b0;
      pend_word_reg  <= 27'h0000000;
    end
    else
    begin
      // A full buffer holds the command here and keeps busy raised
      if (pend_valid_reg && fifo_in_ready)
        pend_valid_reg <= 1'b0;
      if (!selected)
      begin
        state_reg  <= ST_OPC;
        cnt_reg    <= 5'h00;
        ocnt_reg   <= 4'h0;
        so_oe_reg  <= 1'b0;
        rd_end_reg <= 1'b0;
        if (ncs_rise)
        begin
          if (arm_op_reg != `CMD_NONE)
          begin
            pend_valid_reg <= 1'b1;
            pend_word_reg  <= {arm_op_reg, arm_addr_reg, arm_data_reg};
          end
          if (arm_swr_reg)
            protect_reg <= swr_val_reg;
          arm_op_reg  <= `CMD_NONE;
          arm_swr_reg <= 1'b0;
        end
      end
      else if (sck_rise)
      begin
        case (state_reg)
          ST_OPC:
          begin
            sr_reg  <= {sr_reg[14:0], si_bit};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == (`OPC_BITS - 5'h01))
            begin
              cnt_reg   <= 5'h00;
              state_reg <= ST_WAIT;
              case (opcode)
                `OPC_LATCH_SET:
                  if (!busy && !read_only)
                    latch_reg <= 1'b1;
                `OPC_LATCH_CLR:
                  if (!busy && !read_only)
                    latch_reg <= 1'b0;
                `OPC_STAT_RD:
                  if (!read_only)
                    state_reg <= ST_STAT;
                `OPC_STAT_WR:
                  if (!busy && !read_only)
                    state_reg <= ST_SWR;
                `OPC_READ:
                  if (!busy)
                  begin
                    state_reg  <= ST_ADDR;
                    cur_op_reg <= `CMD_NONE;
                  end
                `OPC_WRITE:
                  if (!busy && !read_only)
                  begin
                    state_reg  <= ST_ADDR;
                    cur_op_reg <= `CMD_PROG;
                  end
                `OPC_PART_WIPE:
                  if (!busy && !read_only)
                  begin
                    if (extended_mode)
                    begin
                      state_reg  <= ST_ADDR;
                      cur_op_reg <= `CMD_SECTOR;
                    end
                    else if (latch_reg && !prot_hit(protect_reg, 9'h000))
                    begin
                      arm_op_reg   <= `CMD_SECTOR;
                      arm_addr_reg <= 9'h000;
                    end
                  end
                `OPC_WHOLE_WIPE:
                  if (!busy && !read_only && latch_reg &&
                      (protect_reg == `PROT_RESET))
                  begin
                    arm_op_reg   <= extended_mode ? `CMD_ALL :
                                    `CMD_SECTOR;
                    arm_addr_reg <= 9'h000;
                  end
                default:
                  state_reg <= ST_WAIT;
              endcase
            end
          end
          ST_ADDR:
          begin
            sr_reg  <= {sr_reg[14:0], si_bit};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == (field_len - 5'h01))
            begin
              cnt_reg   <= 5'h00;
              state_reg <= ST_WAIT;
              case (cur_op_reg)
                `CMD_NONE:
                begin
                  rd_addr_reg <= addr_in;
                  state_reg   <= ST_RDATA;
                end
                `CMD_PROG:
                  if (latch_reg && !prot_hit(protect_reg, addr_in))
                  begin
                    arm_addr_reg <= addr_in;
                    state_reg    <= ST_WDATA;
                  end
                default:
                  if (latch_reg &&
                      !prot_hit(protect_reg, {addr_in[8], 8'h00}))
                  begin
                    arm_op_reg   <= `CMD_SECTOR;
                    arm_addr_reg <= {addr_in[8], 8'h00};
                  end
              endcase
            end
          end
          ST_WDATA:
          begin
            sr_reg  <= {sr_reg[14:0], si_bit};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == (field_len - 5'h01))
            begin
              state_reg    <= ST_WAIT;
              arm_op_reg   <= `CMD_PROG;
              // Unused upper byte left erased in Base mode
              arm_data_reg <= extended_mode ? {sr_reg[14:0], si_bit} :
                              {8'hff, sr_reg[6:0], si_bit};
            end
          end
          ST_SWR:
          begin
            sr_reg  <= {sr_reg[14:0], si_bit};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == {1'b0, `STAT_BITS})
            begin
              arm_swr_reg <= 1'b0;
              state_reg   <= ST_WAIT;
            end
            else if (cnt_reg == {1'b0, `STAT_BITS - 4'h1})
            begin
              arm_swr_reg <= 1'b1;
              swr_val_reg <= sr_reg[2:1];
            end
          end
          default:
            state_reg <= state_reg;
        endcase
      end
      else if (sck_fall &&
               ((state_reg == ST_RDATA) || (state_reg == ST_STAT)))
      begin
        if (ocnt_reg == 4'h0)
        begin
          if ((state_reg == ST_RDATA) && rd_end_reg)
            so_oe_reg <= 1'b0;
          else
          begin
            so_reg    <= load_word[15];
            osr_reg   <= {load_word[14:0], 1'b0};
            ocnt_reg  <= load_len;
            so_oe_reg <= 1'b1;
            if (state_reg == ST_RDATA)
            begin
              if (extended_mode)
                rd_addr_reg <= rd_addr_reg + 9'h001;
              else if (rd_addr_reg[7:0] == 8'hff)
                rd_end_reg <= 1'b1;
              else
                rd_addr_reg <= {1'b0, rd_addr_reg[7:0] + 8'h01};
            end
          end
        end
        else
        begin
          so_reg   <= osr_reg[15];
          osr_reg  <= {osr_reg[14:0], 1'b0};
          ocnt_reg <= ocnt_reg - 4'h1;
        end
      end
    end
  end

  cmd_fifo #(
    .WIDTH (`CMD_WIDTH),
    .DEPTH (`CMD_DEPTH),
    .AW    (`CMD_AW)
  ) u_cmd_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (pend_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_reg),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (fifo_out)
  );
endmodule

// ### testbench/spi_flash_checker.sv
// Purpose: Port checks for the serial flash command slave
// Assumes: One clock domain; reset async, active high
// Notes:   Link latencies follow the hand-over figures
`timescale 1ns/100ps
`include "flash_spi_consts.vh"
module spi_flash_checker (
  input wire        clk,
  input wire        reset,
  input wire        sck,
  input wire        ncs,
  input wire        so,
  input wire        so_oe,
  input wire        extended_mode,
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [1:0]  cmd_op,
  input wire [8:0]  cmd_addr,
  input wire [15:0] cmd_data,
  input wire        busy_flag,
  input wire [7:0]  status_byte
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_idle;
    ncs [*6];
  endsequence
  property p_status;
    status_byte[7:4] == 4'h0 && status_byte[`ST_BUSY_BIT] == busy_flag;
  endproperty
  a_status: assert property (p_status)
    else $error("status byte layout wrong");
  property p_idle_oe;
    s_idle |-> !so_oe;
  endproperty
  a_idle_oe: assert property (p_idle_oe)
    else $error("output driven while deselected");
  property p_push;
    $rose(cmd_valid) |-> ncs && $past(ncs, 2) && busy_flag;
  endproperty
  a_push: assert property (p_push)
    else $error("command raised while selected");
  property p_latch;
    $changed(status_byte[`ST_LATCH_BIT]) |-> !ncs;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch moved outside a transfer");
  property p_prot;
    $changed(status_byte[3:2]) |-> ncs;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protect bits moved before deselect");
  property p_so_edge;
    so_oe && $past(so_oe) && $changed(so) |-> !$past(sck, 3);
  endproperty
  a_so_edge: assert property (p_so_edge)
    else $error("output changed off the falling edge");
  property p_hold;
    cmd_valid && !cmd_ready |=> cmd_valid &&
      $stable({cmd_op, cmd_addr, cmd_data});
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled command changed");
  property p_grant;
    cmd_valid |-> status_byte[`ST_LATCH_BIT] &&
      status_byte[3:2] != `PROT_FULL && (extended_mode || !cmd_addr[8]);
  endproperty
  a_grant: assert property (p_grant)
    else $error("command without latch or in protected space");
endmodule

// ### testbench/spi_master_model.sv
// Purpose: Serial master driving the slave's link pins, mode 0
// Assumes: Bench clk paces the link at 130 ns per bit
// Notes:   Received bits and drive flags are left in rx and oe
`timescale 1ns/100ps
module spi_master_model (
  input  wire  clk,
  output logic sck,
  output logic ncs,
  output logic si,
  input  wire  so,
  input  wire  so_oe
);
  logic [63:0] rx;
  logic [63:0] oe;
  initial
    {sck, ncs, si} = 3'b010;
  // Released data line toggles so a stale bit never passes as data
  always @(posedge clk)
    if (ncs)
      si <= #1 ~si;
  task automatic half(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frame(input int n, input logic [63:0] tx);
    rx = '0;
    oe = '0;
    half(1);
    ncs = 1'b0;
    half(80);
    for (int i = n - 1; i >= 0; i--)
    begin
      si = tx[i];
      half(6);
      sck = 1'b1;
      // Undriven line reads as its pull-down, so stale bits never count
      rx = {rx[62:0], so_oe ? so : 1'b0};
      oe = {oe[62:0], so_oe};
      half(7);
      sck = 1'b0;
    end
    half(6);
    ncs = 1'b1;
    half(70);
  endtask
endmodule

// ### testbench/tb.sv
// Purpose: Self-checking bench for the serial flash command slave
// Assumes: Array and flash engine are modelled here
// Notes:   Engine busy 20 clk per command keeps busy windows short
`timescale 1ns/100ps
module tb;
  logic        clk, reset, extended_mode, read_only, engine_busy, cmd_ready;
  logic        hold;
  logic [15:0] a, d;
  logic [26:0] popped[$];
  int          busy_cnt, num_errors, tests_run;
  wire         sck, ncs, si, so, so_oe, cmd_valid, busy_flag;
  wire [8:0]   flash_rd_addr, cmd_addr;
  wire [15:0]  flash_rd_data, cmd_data;
  wire [1:0]   cmd_op;
  wire [7:0]   status_byte;
  function automatic logic [15:0] mw(input logic [8:0] x);
    return {~x[7:0], x[7:0] ^ {x[8], 7'h00}};
  endfunction
  assign flash_rd_data = mw(flash_rd_addr);
  flash_spi_slave flash_spi_slave_inst (.clk, .reset, .sck, .ncs, .si,
    .so, .so_oe, .extended_mode, .read_only, .flash_rd_addr,
    .flash_rd_data, .engine_busy, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_data, .busy_flag, .status_byte);
  spi_master_model m (.clk, .sck, .ncs, .si, .so, .so_oe);
  always #5 clk = ~clk;
  // Engine takes commands at random moments so the buffer head stalls
  always @(posedge clk)
  begin
    if (cmd_valid && cmd_ready && !reset)
    begin
      popped.push_back({cmd_op, cmd_addr, cmd_data});
      busy_cnt = 20;
    end
    else if (busy_cnt > 0)
      busy_cnt--;
    engine_busy <= #1 hold || busy_cnt > 0;
    cmd_ready <= #1 !hold && busy_cnt == 0 && $urandom % 2;
  end
  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic stat(input logic [7:0] e);
    m.frame(24, {40'h0, 8'h05, 16'($urandom)});
    chk("status", {48'h0, e, e}, m.rx);
  endtask
  task automatic fc(input int n, input logic [63:0] t, input logic [26:0] e);
    logic [26:0] g;
    m.frame(n, t);
    repeat (400) if (popped.size() == 0) @(posedge clk);
    g = popped.size() ? popped.pop_front() : 'x;
    if (e[26:25] != 2'h1)
      g[15:0] = e[15:0];
    chk("command", 64'(e), 64'(g));
    repeat (400) if (busy_flag !== 1'b0) @(posedge clk);
  endtask
  task automatic fn(input int n, input logic [63:0] t);
    m.frame(n, t);
    repeat (40) @(posedge clk);
    chk("queued", 0, 64'(popped.size()));
  endtask
  task automatic rst(input logic ext, input logic ro);
    #1 {reset, extended_mode, read_only} = {1'b1, ext, ro};
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {clk, reset, hold, engine_busy, cmd_ready} = 5'b01000;
    {extended_mode, read_only, busy_cnt} = '0;
    void'($urandom(32'hde7e4031));
    rst(1'b1, 1'b0);
    a = $urandom;
    d = $urandom;
    stat(8'h00);
    fn(40, {24'h0, 8'h02, a, d});
    m.frame(16, {48'h0, 8'h06, 8'hff});
    stat(8'h02);
    fc(40, {24'h0, 8'h02, a, d}, {2'h1, a[8:0], d});
    stat(8'h02);
    m.frame(16, {48'h0, 8'h01, 8'hff});
    stat(8'h0e);
    fn(40, {24'h0, 8'h02, a, d});
    fn(24, {40'h0, 8'h20, 16'h0100});
    m.frame(17, {47'h0, 8'h01, 9'h000});
    stat(8'h0e);
    m.frame(15, {49'h0, 8'h01, 7'h00});
    stat(8'h0e);
    m.frame(16, {48'h0, 8'h01, 8'hf3});
    stat(8'h02);
    fc(24, {40'h0, 8'h20, a[15:9], 9'h100}, {2'h2, 9'h100, 16'h0});
    fc(8, {56'h0, 8'h60}, {2'h3, 9'h000, 16'h0});
    m.frame(56, {8'h0, 8'h03, a[15:9], 9'h1ff, 32'h0});
    chk("read", {32'h0, mw(9'h1ff), mw(9'h000)}, m.rx);
    hold = 1'b1;
    stat(8'h03);
    m.frame(8, {56'h0, 8'h04});
    fn(40, {24'h0, 8'h02, a, d});
    m.frame(40, {24'h0, 8'h03, a, 16'h0});
    chk("busy drive", 0, m.oe);
    hold = 1'b0;
    stat(8'h02);
    fn(40, {24'h0, 8'hff, 8'h02, a[7:0], d});
    chk("stray drive", 0, m.oe);
    m.frame(8, {56'h0, 8'h04});
    stat(8'h00);
    rst(1'b0, 1'b0);
    m.frame(40, {24'h0, 8'h03, 8'hfe, 24'h0});
    chk("base read", 16'hfeff, m.rx[23:8]);
    chk("base stop", 24'hffff00, m.oe);
    m.frame(8, {56'h0, 8'h06});
    fc(24, {40'h0, 8'h02, a[7:0], d[7:0]},
       {3'h2, a[7:0], 8'hff, d[7:0]});
    fc(8, {56'h0, 8'h20}, {2'h2, 9'h000, 16'h0});
    fc(8, {56'h0, 8'h60}, {2'h2, 9'h000, 16'h0});
    rst(1'b1, 1'b1);
    m.frame(8, {56'h0, 8'h06});
    fn(40, {24'h0, 8'h02, a, d});
    m.frame(24, {40'h0, 8'h05, 16'h0});
    chk("ro drive", 0, m.oe);
    wrap_up();
  end
  initial
  begin
    #900000 num_errors++;
    wrap_up();
  end
endmodule
bind flash_spi_slave spi_flash_checker spi_flash_checker_inst (.clk,
  .reset, .sck, .ncs, .so, .so_oe, .extended_mode, .cmd_valid, .cmd_ready,
  .cmd_op, .cmd_addr, .cmd_data, .busy_flag, .status_byte);
